// [pfd_top.sv]
// Contract
// R1: bits 31-30 pick pin15 gpio or mgmt clock
// R2: bits 29-28 pick pin14 gpio or rx error
// R3: bits 27-24 pick pins 13,12 or rx lines 1,2
// R4: bits 23-22 pick pin11 or rx line 3
// R5: bits 21-16 pick pins 10-8 or tx lines
// R6: bits 15-14 pick pin7 or timer0 output
// R7: bits 13-12 offer only gpio pin6
// R8: bits 11-10 pick pin5 or transfer acknowledge
// R9: direction bit matters only on gpio pins
// R10: output drives last latched data value
// R11: reset clears all direction bits
// R12: first direction write disables pull-ups
// R13: direction bit 0 input, 1 output
// R14: port b has its own direction register
// R15: boot software sets direction before outputs
// R16: registers read back; reserved codes stay gpio-off
module pfd_top
   import pfd_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_N_I,
   // ahb-lite slave
   input  wire logic        HSEL_I,
   input  wire logic [7:0]  HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // gpio data latches, same clock domain
   input  wire logic [15:0] PORTA_LATCH_I,
   input  wire logic [15:0] PORTB_LATCH_I,
   // port a pins, gpio only in this block
   input  wire logic [15:0] PORTA_PIN_I,
   output logic      [15:0] PORTA_PIN_O,
   output logic      [15:0] PORTA_PIN_OE_O,
   output logic             PORTA_PULL_EN_O,
   output logic      [15:0] PORTA_IN_O,
   // port b pins
   input  wire logic [15:0] PORTB_PIN_I,
   output logic      [15:0] PORTB_PIN_O,
   output logic      [15:0] PORTB_PIN_OE_O,
   output logic             PORTB_PULL_EN_O,
   output logic      [15:0] PORTB_IN_O,
   // alternate functions: outputs toward pins
   input  wire logic        ETH_MGMT_CLK_I,
   input  wire logic [3:1]  ETH_TRANSMIT_LINE_I,
   input  wire logic        TIMER0_OUTPUT_I,
   input  wire logic        XFER_ACK_I,
   input  wire logic        XFER_ACK_OE_I,
   // alternate functions: inputs from pins
   output logic             ETH_RECEIVE_ERROR_O,
   output logic      [3:1]  ETH_RECEIVE_LINE_O,
   output logic             XFER_ACK_O
);
   import pfd_pkg::*;

   pfd_regs_if regs ();

   pfd_regfile u_regfile (
      .clk_i     (CORE_CLK_I),
      .reset_n_i (RESET_N_I),
      .regs      (regs)
   );

   // ---- bus slave: address phase then one-cycle data phase ----
   pfd_bus_state_t st_reg, st_next;
   logic [7:0]     ofs_reg, ofs_next;
   logic           wr_reg,  wr_next;
   logic [31:0]    rdata_reg, rdata_next;

   logic        addr_take;
   logic [31:0] status_word;

   // a transfer is taken only when the bus is ready and we are selected
   assign addr_take = HSEL_I && HREADY_I &&
                      (HTRANS_I == PFD_HTRANS_NONSEQ ||
                       HTRANS_I == PFD_HTRANS_SEQ);

   // status shows pull-up state and which pins are gpio
   logic [15:0] gpio_mask;
   assign status_word = {14'h0000, regs.portb_pull_en,
                         regs.porta_pull_en, gpio_mask};

   always_comb begin
      st_next    = PFD_ST_IDLE;
      ofs_next   = ofs_reg;
      wr_next    = 1'b0;
      rdata_next = rdata_reg;
      if (addr_take) begin
         st_next  = PFD_ST_DATA;
         ofs_next = {HADDR_I[7:2], 2'b00};
         wr_next  = HWRITE_I;
         // read data registered so it stands in the data phase
         case ({HADDR_I[7:2], 2'b00})
            PFD_OFS_PORTB_FUNC: rdata_next = regs.func_sel;      // [R16]
            PFD_OFS_PORTA_DIR:  rdata_next = {16'h0000, regs.porta_dir};
            PFD_OFS_PORTB_DIR:  rdata_next = {16'h0000, regs.portb_dir};
            PFD_OFS_STATUS:     rdata_next = status_word;
            default:            rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_reg    <= PFD_ST_IDLE;
         ofs_reg   <= 8'h00;
         wr_reg    <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         st_reg    <= st_next;
         ofs_reg   <= ofs_next;
         wr_reg    <= wr_next;
         rdata_reg <= rdata_next;
      end
   end

   // write lands in the data phase, when hwdata is valid
   assign regs.wr_en   = (st_reg == PFD_ST_DATA) && wr_reg;
   assign regs.wr_ofs  = ofs_reg;
   assign regs.wr_data = HWDATA_I;

   // zero wait states, always okay
   assign HRDATA_O    = rdata_reg;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;

   // ---- pin input synchronisers ----
   logic [15:0] pa_s1_reg, pa_s2_reg;
   logic [15:0] pb_s1_reg, pb_s2_reg;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         pa_s1_reg <= 16'h0000;
         pa_s2_reg <= 16'h0000;
         pb_s1_reg <= 16'h0000;
         pb_s2_reg <= 16'h0000;
      end else begin
         pa_s1_reg <= PORTA_PIN_I;
         pa_s2_reg <= pa_s1_reg;
         pb_s1_reg <= PORTB_PIN_I;
         pb_s2_reg <= pb_s1_reg;
      end
   end

   // ---- port b function decode ----
   // reserved codes enable nothing: pin is neither gpio nor alternate
   logic [15:0] alt_mask;
   logic [15:0] altout_val;
   logic [15:0] altout_en;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_pin
         if (gi >= PFD_FIRST_FIELD) begin : g_field
            logic [1:0] code;
            assign code = regs.func_sel[PFD_FIELD_W*gi+1:PFD_FIELD_W*gi];
            assign gpio_mask[gi] = (code == PFD_SEL_GPIO);
            // pin 6 has no alternate function at all
            assign alt_mask[gi]  = (code == PFD_SEL_ALT) &&
                                   PFD_ALT_PRESENT[gi];  // [R7] [R16]
         end else begin : g_plain
            // lower fields are handled elsewhere; treat as gpio here
            assign gpio_mask[gi] = 1'b1;
            assign alt_mask[gi]  = 1'b0;
         end
      end
   endgenerate

   // alternate function output drive; inputs-only functions never drive
   always_comb begin
      altout_val = 16'h0000;
      altout_en  = 16'h0000;
      altout_val[15] = ETH_MGMT_CLK_I;          // [R1]
      altout_en[15]  = alt_mask[15];
      altout_val[10] = ETH_TRANSMIT_LINE_I[1];  // [R5]
      altout_en[10]  = alt_mask[10];
      altout_val[9]  = ETH_TRANSMIT_LINE_I[2];  // [R5]
      altout_en[9]   = alt_mask[9];
      altout_val[8]  = ETH_TRANSMIT_LINE_I[3];  // [R5]
      altout_en[8]   = alt_mask[8];
      altout_val[7]  = TIMER0_OUTPUT_I;         // [R6]
      altout_en[7]   = alt_mask[7];
      // transfer acknowledge is two-way; its owner steers direction
      altout_val[5]  = XFER_ACK_I;              // [R8]
      altout_en[5]   = alt_mask[5] && XFER_ACK_OE_I;
   end

   // ---- registered pin outputs ----
   logic [15:0] pa_o_reg, pa_oe_reg, pa_in_reg;
   logic [15:0] pb_o_reg, pb_oe_reg, pb_in_reg;
   logic        pa_pull_reg, pb_pull_reg;
   logic        rxer_reg, ack_in_reg;
   logic [3:1]  rxd_reg;
   logic [15:0] pa_o_next, pa_oe_next, pa_in_next;
   logic [15:0] pb_o_next, pb_oe_next, pb_in_next;
   logic        rxer_next, ack_in_next;
   logic [3:1]  rxd_next;

   always_comb begin
      // direction 1 drives the latched data value; no reset-time drive
      // since direction resets to input and boot code must set it
      pa_oe_next = regs.porta_dir;                       // [R13] [R15]
      pa_o_next  = PORTA_LATCH_I & regs.porta_dir;       // [R10]
      pa_in_next = pa_s2_reg;
      // gpio pins obey direction; alternate pins ignore it
      pb_oe_next = (regs.portb_dir & gpio_mask)
                   | altout_en;                          // [R9] [R14]
      pb_o_next  = (PORTB_LATCH_I & regs.portb_dir & gpio_mask)
                   | (altout_val & altout_en);           // [R10]
      pb_in_next = pb_s2_reg & gpio_mask;
      // receive functions see the pin only when selected
      rxer_next   = pb_s2_reg[14] & alt_mask[14];        // [R2]
      rxd_next[1] = pb_s2_reg[13] & alt_mask[13];        // [R3]
      rxd_next[2] = pb_s2_reg[12] & alt_mask[12];        // [R3]
      rxd_next[3] = pb_s2_reg[11] & alt_mask[11];        // [R4]
      ack_in_next = pb_s2_reg[5]  & alt_mask[5];         // [R8]
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         pa_o_reg    <= 16'h0000;
         pa_oe_reg   <= 16'h0000;   // [R11]
         pa_in_reg   <= 16'h0000;
         pb_o_reg    <= 16'h0000;
         pb_oe_reg   <= 16'h0000;   // [R11]
         pb_in_reg   <= 16'h0000;
         pa_pull_reg <= 1'b1;
         pb_pull_reg <= 1'b1;
         rxer_reg    <= 1'b0;
         rxd_reg     <= 3'h0;
         ack_in_reg  <= 1'b0;
      end else begin
         pa_o_reg    <= pa_o_next;
         pa_oe_reg   <= pa_oe_next;
         pa_in_reg   <= pa_in_next;
         pb_o_reg    <= pb_o_next;
         pb_oe_reg   <= pb_oe_next;
         pb_in_reg   <= pb_in_next;
         pa_pull_reg <= regs.porta_pull_en;  // [R12]
         pb_pull_reg <= regs.portb_pull_en;  // [R12]
         rxer_reg    <= rxer_next;
         rxd_reg     <= rxd_next;
         ack_in_reg  <= ack_in_next;
      end
   end

   assign PORTA_PIN_O         = pa_o_reg;
   assign PORTA_PIN_OE_O      = pa_oe_reg;
   assign PORTA_IN_O          = pa_in_reg;
   assign PORTA_PULL_EN_O     = pa_pull_reg;
   assign PORTB_PIN_O         = pb_o_reg;
   assign PORTB_PIN_OE_O      = pb_oe_reg;
   assign PORTB_IN_O          = pb_in_reg;
   assign PORTB_PULL_EN_O     = pb_pull_reg;
   assign ETH_RECEIVE_ERROR_O = rxer_reg;
   assign ETH_RECEIVE_LINE_O  = rxd_reg;
   assign XFER_ACK_O          = ack_in_reg;
endmodule // pfd_top

// [pfd_pkg.sv]
package pfd_pkg;
   // register byte offsets on the bus
   localparam logic [7:0]  PFD_OFS_PORTB_FUNC = 8'h00;
   localparam logic [7:0]  PFD_OFS_PORTA_DIR  = 8'h04;
   localparam logic [7:0]  PFD_OFS_PORTB_DIR  = 8'h08;
   localparam logic [7:0]  PFD_OFS_STATUS     = 8'h0C;
   // values after reset
   localparam logic [31:0] PFD_FUNC_RST       = 32'h0000_0000;
   localparam logic [15:0] PFD_DIR_RST        = 16'h0000;
   // field positions: pin n occupies bits [2n+1:2n]
   localparam int          PFD_FIELD_W        = 2;
   localparam int          PFD_FIRST_FIELD    = 5;
   // function codes
   localparam logic [1:0]  PFD_SEL_GPIO       = 2'h0;
   localparam logic [1:0]  PFD_SEL_ALT        = 2'h1;
   // mask of pins that own an alternate function: 15..7 and 5;
   // pin 6 has none and pins 4..0 are outside this block
   localparam logic [15:0] PFD_ALT_PRESENT    = 16'hFFA0;
   // bus transfer codes
   localparam logic [1:0]  PFD_HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  PFD_HTRANS_SEQ     = 2'h3;
   typedef enum logic [0:0] {
      PFD_ST_IDLE = 1'b0,
      PFD_ST_DATA = 1'b1
   } pfd_bus_state_t;
endpackage

// [pfd_regs_if.sv]
interface pfd_regs_if;
   import pfd_pkg::*;
   logic        wr_en;
   logic [7:0]  wr_ofs;
   logic [31:0] wr_data;
   logic [31:0] func_sel;
   logic [15:0] porta_dir;
   logic [15:0] portb_dir;
   logic        porta_pull_en;
   logic        portb_pull_en;
   modport owner (input wr_en, wr_ofs, wr_data,
                  output func_sel, porta_dir, portb_dir,
                  porta_pull_en, portb_pull_en);
   modport user  (output wr_en, wr_ofs, wr_data,
                  input func_sel, porta_dir, portb_dir,
                  porta_pull_en, portb_pull_en);
endinterface

// [pfd_regfile.sv]
module pfd_regfile
   import pfd_pkg::*;
(
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  reset_n_i,
   // register access
   pfd_regs_if.owner  regs
);
   import pfd_pkg::*;

   logic [31:0] func_reg,  func_next;
   logic [15:0] adir_reg,  adir_next;
   logic [15:0] bdir_reg,  bdir_next;
   logic        apull_reg, apull_next;
   logic        bpull_reg, bpull_next;

   // next values from bus writes; registers read back as written
   always_comb begin
      func_next  = func_reg;
      adir_next  = adir_reg;
      bdir_next  = bdir_reg;
      apull_next = apull_reg;
      bpull_next = bpull_reg;
      if (regs.wr_en) begin
         case (regs.wr_ofs)
            PFD_OFS_PORTB_FUNC: func_next = regs.wr_data; // [R16]
            PFD_OFS_PORTA_DIR: begin
               adir_next  = regs.wr_data[15:0];  // [R13]
               apull_next = 1'b0;                // [R12]
            end
            PFD_OFS_PORTB_DIR: begin
               bdir_next  = regs.wr_data[15:0];  // [R14]
               bpull_next = 1'b0;                // [R12]
            end
            default: begin
            end
         endcase
      end
   end

   // pull-ups start enabled; each cleared only by the first write to its own port's direction register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         func_reg  <= PFD_FUNC_RST;
         adir_reg  <= PFD_DIR_RST;   // [R11]
         bdir_reg  <= PFD_DIR_RST;   // [R11]
         apull_reg <= 1'b1;
         bpull_reg <= 1'b1;
      end else begin
         func_reg  <= func_next;
         adir_reg  <= adir_next;
         bdir_reg  <= bdir_next;
         apull_reg <= apull_next;
         bpull_reg <= bpull_next;
      end
   end

   assign regs.func_sel      = func_reg;
   assign regs.porta_dir     = adir_reg;
   assign regs.portb_dir     = bdir_reg;
   assign regs.porta_pull_en = apull_reg;
   assign regs.portb_pull_en = bpull_reg;
endmodule // pfd_regfile

// [pfd_top_assertions.sv]
module pfd_top_assertions
   import pfd_pkg::*;
(
   // clock, reset and bus
   input wire logic        CORE_CLK_I,
   input wire logic        RESET_N_I,
   input wire logic        HSEL_I,
   input wire logic [1:0]  HTRANS_I,
   input wire logic        HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic        HREADYOUT_O,
   input wire logic        HRESP_O,
   // pins
   input wire logic [15:0] PORTA_LATCH_I,
   input wire logic [15:0] PORTA_PIN_I,
   input wire logic [15:0] PORTA_PIN_O,
   input wire logic [15:0] PORTA_PIN_OE_O,
   input wire logic        PORTA_PULL_EN_O,
   input wire logic [15:0] PORTA_IN_O,
   input wire logic [15:0] PORTB_LATCH_I,
   input wire logic [15:0] PORTB_PIN_O,
   input wire logic [15:0] PORTB_PIN_OE_O,
   input wire logic        PORTB_PULL_EN_O
);
   logic [1:0] up_cnt_reg;
   logic [1:0] up_cnt_next;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // cycles since reset, so the sync pipeline is full before we judge it
   always_comb up_cnt_next = (up_cnt_reg == 2'h3) ? 2'h3 : up_cnt_reg + 2'h1;
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) up_cnt_reg <= 2'h0;
      else up_cnt_reg <= up_cnt_next;
   end
   property p_okay; HREADYOUT_O && !HRESP_O; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or error");
   property p_reset_dir;
      $rose(RESET_N_I) |-> PORTA_PIN_OE_O == 16'h0 && PORTB_PIN_OE_O == 16'h0;
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("drive on reset");
   property p_pulla; !PORTA_PULL_EN_O |=> !PORTA_PULL_EN_O; endproperty
   a_pulla: assert property (p_pulla) else $error("port a pull back on");
   property p_pullb; !PORTB_PULL_EN_O |=> !PORTB_PULL_EN_O; endproperty
   a_pullb: assert property (p_pullb) else $error("port b pull back on");
   property p_porta_out;
      PORTA_PIN_O == ($past(PORTA_LATCH_I) & PORTA_PIN_OE_O);
   endproperty
   a_porta_out: assert property (p_porta_out) else $error("port a value");
   property p_pin6; PORTB_PIN_OE_O[6] |-> PORTB_PIN_O[6] == $past(PORTB_LATCH_I[6]);
   endproperty
   a_pin6: assert property (p_pin6) else $error("pin6 not latch value");
   property p_rdata;
      !$past(HSEL_I && HREADY_I && HTRANS_I[1]) |-> $stable(HRDATA_O);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved");
   property p_ain; up_cnt_reg == 2'h3 |-> PORTA_IN_O == $past(PORTA_PIN_I, 3);
   endproperty
   a_ain: assert property (p_ain) else $error("port a input path");
endmodule // pfd_top_assertions

bind pfd_top pfd_top_assertions u_chk (.*);

// [pfd_top_bench.sv]
module pfd_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pfd_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, d;
   logic [15:0] a_lat = 16'h0, b_lat = 16'h0, a_pin = 16'h0, b_pin = 16'h0;
   logic [15:0] a_out, a_oe, a_in, b_out, b_oe, b_in;
   logic        a_pull, b_pull, mdc = 1'b0, tmr = 1'b0, ack = 1'b0;
   logic        ack_oe = 1'b0, rxer, ack_in;
   logic [3:1]  txl = 3'h0, rxl;
   int n_errors = 0, total_checks = 0;
   // expected pin state per function code 00, 01, 10, 11
   logic [15:0] oe_e [4] = '{16'hFFFF, 16'h87BF, 16'h001F, 16'h001F};
   logic [15:0] out_e [4] = '{16'hFFFF, 16'h843F, 16'h001F, 16'h001F};
   logic [15:0] in_e [4] = '{16'hE7FF, 16'h001F, 16'h001F, 16'h001F};
   logic [4:0]  rx_e [4] = '{5'h00, 5'h13, 5'h00, 5'h00};
   // clock
   always #2.5 clk = ~clk;
   pfd_top dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .PORTA_LATCH_I(a_lat), .PORTB_LATCH_I(b_lat), .PORTA_PIN_I(a_pin),
      .PORTA_PIN_O(a_out), .PORTA_PIN_OE_O(a_oe), .PORTA_PULL_EN_O(a_pull),
      .PORTA_IN_O(a_in), .PORTB_PIN_I(b_pin), .PORTB_PIN_O(b_out),
      .PORTB_PIN_OE_O(b_oe), .PORTB_PULL_EN_O(b_pull), .PORTB_IN_O(b_in),
      .ETH_MGMT_CLK_I(mdc), .ETH_TRANSMIT_LINE_I(txl), .TIMER0_OUTPUT_I(tmr),
      .XFER_ACK_I(ack), .XFER_ACK_OE_I(ack_oe), .ETH_RECEIVE_ERROR_O(rxer),
      .ETH_RECEIVE_LINE_O(rxl), .XFER_ACK_O(ack_in));
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // bounded wait for hready at the next edges
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) begin
         n_errors++;
         finish_test();
      end
   endtask
   // one single word transfer; read data taken at the data phase edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= PFD_HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic t_reset();
      xfer(1'b0, PFD_OFS_PORTA_DIR, 32'h0, d);
      chk(d, 32'h0);
      xfer(1'b0, PFD_OFS_PORTB_DIR, 32'h0, d);
      chk(d, 32'h0);
      chk({a_pull, b_pull}, 2'h3);
      chk({a_oe, b_oe}, 32'h0);
   endtask
   task automatic t_dir();
      a_lat <= 16'h0FF0;
      a_pin <= 16'h3C5A;
      xfer(1'b1, PFD_OFS_PORTA_DIR, 32'hFFFF_1234, d);
      repeat (3) @(posedge clk);
      chk({a_pull, b_pull}, 2'h1);
      chk({a_oe, a_out}, {16'h1234, 16'h0230});
      chk(a_in, 16'h3C5A);
      xfer(1'b0, PFD_OFS_PORTA_DIR, 32'h0, d);
      chk(d, 32'h1234);
      xfer(1'b0, PFD_OFS_PORTB_DIR, 32'h0, d);
      chk(d, 32'h0);
      b_lat <= 16'hFFFF;
      xfer(1'b1, PFD_OFS_PORTB_DIR, 32'h0000_00F0, d);
      repeat (3) @(posedge clk);
      chk({b_pull, b_oe, b_out}, {1'b0, 16'h00F0, 16'h00F0});
   endtask
   // every code in every field at once, with alternate inputs set to a mix of ones and zeros
   task automatic t_func();
      logic [31:0] f;
      b_pin <= 16'hE7FF;
      mdc <= 1'b1;
      txl <= 3'b001;
      ack <= 1'b1;
      ack_oe <= 1'b1;
      xfer(1'b1, PFD_OFS_PORTB_DIR, 32'h0000_FFFF, d);
      for (int c = 0; c < 4; c++) begin
         f = {16{c[1:0]}};
         xfer(1'b1, PFD_OFS_PORTB_FUNC, f, d);
         repeat (5) @(posedge clk);
         xfer(1'b0, PFD_OFS_PORTB_FUNC, 32'h0, d);
         chk(d, f);
         chk(b_oe, oe_e[c]);
         chk(b_out & b_oe, out_e[c]);
         chk({rxer, rxl, ack_in, b_in}, {rx_e[c], in_e[c]});
      end
      // acknowledge selected but its owner not driving: pin must float
      ack_oe <= 1'b0;
      xfer(1'b1, PFD_OFS_PORTB_FUNC, 32'h0000_0400, d);
      repeat (3) @(posedge clk);
      chk(b_oe, 16'hFFDF);
   endtask
   task automatic t_unmapped();
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF, d);
      xfer(1'b1, PFD_OFS_STATUS, 32'hFFFF_FFFF, d);
      xfer(1'b0, 8'h10, 32'h0, d);
      chk(d, 32'h0);
      xfer(1'b0, PFD_OFS_PORTA_DIR, 32'h0, d);
      chk(d, 32'h1234);
      xfer(1'b0, PFD_OFS_STATUS, 32'h0, d);
      chk(d, 32'h0000_FFDF);
   endtask
   // reset in mid-run must clear what earlier scenarios wrote
   task automatic t_rereset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      xfer(1'b0, PFD_OFS_PORTA_DIR, 32'h0, d);
      chk(d, 32'h0);
      xfer(1'b0, PFD_OFS_PORTB_DIR, 32'h0, d);
      chk(d, 32'h0);
      chk({a_pull, b_pull}, 2'h3);
      chk({a_oe, b_oe}, 32'h0);
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_dir();
      t_func();
      t_unmapped();
      t_rereset();
      finish_test();
   end
endmodule // pfd_top_bench
